/* inc/adcs_pkg.sv */
// Shared constants and types for the converter sequencer and serial port
package adcs_pkg;

  // Command bytes, bit 0 is don't care in sync and sleep
  localparam logic [7:0] CMD_IGNORE_LSB = 8'hFE;
  localparam logic [7:0] CMD_START = 8'h08;
  localparam logic [7:0] CMD_SLEEP = 8'h02;
  localparam logic [3:0] CMD_RD_NIB = 4'h2;
  localparam logic [3:0] CMD_WR_NIB = 4'h4;

  // Operating mode encoding, normal is the reset value of the setting
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_DUTY = 2'h1;
  localparam logic [1:0] MODE_TURBO = 2'h2;

  // Timing in system clock or modulator periods
  localparam int SYS_DIV_DEFAULT = 49;
  localparam logic [3:0] MOD_DIV_NORMAL = 4'hF;
  localparam logic [3:0] MOD_DIV_TURBO = 4'h7;
  localparam int START_DLY_NORMAL = 210;
  localparam int START_DLY_TURBO = 114;
  localparam int TIMEOUT_NORMAL = 13955;
  localparam int TIMEOUT_TURBO = 27910;
  localparam logic [16:0] DUTY_SLEEP_PERIODS = 17'h00003;
  localparam logic [16:0] READY_PULSE_MOD = 17'h00002;
  localparam int RESULT_W = 24;

  // Reset values
  localparam logic RST_READY_N = 1'b1;
  localparam logic RST_DOUT = 1'b1;

  // Conversion length in modulator periods for each rate code
  function automatic logic [16:0] rate_period(input logic [2:0] rate);
    logic [16:0] p;
    p = 17'h00100;
    case (rate)
      3'h0: p = 17'h03200;
      3'h1: p = 17'h01639;
      3'h2: p = 17'h00B1C;
      3'h3: p = 17'h005B6;
      3'h4: p = 17'h00307;
      3'h5: p = 17'h001AA;
      default: p = 17'h00100;
    endcase
    return p;
  endfunction

  typedef enum logic [3:0] {
    CV_IDLE = 4'b0001,
    CV_DELAY = 4'b0010,
    CV_CONV = 4'b0100,
    CV_DUTY = 4'b1000
  } adcs_conv_state_type;

  typedef enum logic [2:0] {
    SP_CMD = 3'b001,
    SP_WR = 3'b010,
    SP_RD = 3'b100
  } adcs_sp_phase_type;

endpackage

/* src/adcs_seq_port.sv */
// Conversion sequencer, operating modes and mode-1 serial slave port
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Continuous mode stores result, restarts immediately
// - Continuous starts on sync; 210/114 clock delay
// - Configuration write restarts conversion in progress
// - Normal mode default; modulator is clock/16
// - Rate code picks period; scales with clock
// - Duty mode: one conversion, three periods asleep
// - Turbo mode modulator is clock/8
// - Sleep finishes conversion, then powers analog down; sleep in duty rest only sets power-down, conversions resume
// - Powered down keeps settings, takes commands
// - Sync wakes; single or continuous per bit
// - Config write wakes; exactly one conversion
// - Clock idles low, shift rise, sample fall
// - Chip select high resets port, tristates output
// - Ready falls on data, rises on clock
// - Dedicated ready output always driven
// - Data input sampled on falling clock only
// - Shared output changes on rising clock edges
// - Shared output mirrors ready fall when selected and port idle
// - Incomplete command times out, port resets
// - Register commands complete after data bytes
// - Result is 24-bit two's complement
// - Sync byte 0000100x, sleep byte 0000001x
// - Result shifted out three bytes, MSB first
// - Single-shot: one conversion, then low power
module adcs_seq_port #(
  parameter int SYS_DIV = adcs_pkg::SYS_DIV_DEFAULT,
  parameter int START_DLY_N = adcs_pkg::START_DLY_NORMAL,
  parameter int START_DLY_T = adcs_pkg::START_DLY_TURBO,
  parameter int TOUT_N = adcs_pkg::TIMEOUT_NORMAL,
  parameter int TOUT_T = adcs_pkg::TIMEOUT_TURBO
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Serial port
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_din,
  output logic o_dout,
  output logic o_dout_oe_n,
  output logic o_ready_n,
  // Configuration settings
  input wire logic i_conv_mode_bit,
  input wire logic [1:0] i_op_mode,
  input wire logic [2:0] i_rate_select,
  input wire logic i_ready_on_dout_select,
  // Configuration register access
  output logic o_reg_wr_en,
  output logic [1:0] o_reg_wr_addr,
  output logic [7:0] o_reg_wr_data,
  output logic [1:0] o_reg_rd_addr,
  input wire logic [7:0] i_reg_rd_data,
  // Converter core
  input wire logic [adcs_pkg::RESULT_W-1:0] i_conv_result,
  output logic o_mod_tick,
  output logic o_conv_start,
  output logic o_converting,
  output logic o_analog_on,
  output logic o_excitation_on,
  output logic o_low_side_allow,
  output logic o_powered_down
);

  if (SYS_DIV < 2 || START_DLY_N < 1 || START_DLY_T < 1 || TOUT_N < 1 || TOUT_T < 1 ||
      TOUT_N > 32767 || TOUT_T > 32767 || SYS_DIV > 255 || START_DLY_N > 65535) begin : g_chk
    $error("adcs_seq_port: parameter out of range");
  end

  localparam logic [7:0] SYS_LAST = 8'(SYS_DIV - 1);
  localparam logic [16:0] DLY_N_LAST = 17'(START_DLY_N - 1);
  localparam logic [16:0] DLY_T_LAST = 17'(START_DLY_T - 1);
  localparam logic [14:0] TOUT_N_LAST = 15'(TOUT_N - 1);
  localparam logic [14:0] TOUT_T_LAST = 15'(TOUT_T - 1);

  logic turbo, duty, sys_tick, mod_tick, sclk_q_r, sclk_rise, sclk_fall;
  logic cont_r, sleep_pend_r, pd_r, conv_done, dly_done, duty_done, ready_n_r;
  logic byte_done, sp_busy, tout_hit, sp_reset, dout_r;
  logic start_cmd_r, sleep_cmd_r, cfg_wr_r, load_rd_r;
  logic [7:0] div_cnt_r;
  logic [3:0] mod_cnt_r;
  adcs_pkg::adcs_conv_state_type cv_state_r;
  logic [16:0] cnt_r, period;
  logic [adcs_pkg::RESULT_W-1:0] result_r, tx_r;
  adcs_pkg::adcs_sp_phase_type sp_phase_r;
  logic [7:0] rx_r, rx_nxt;
  logic [2:0] bit_cnt_r;
  logic [1:0] left_r, addr_r;
  logic [14:0] tout_r;

  assign turbo = (i_op_mode == adcs_pkg::MODE_TURBO);
  assign duty = (i_op_mode == adcs_pkg::MODE_DUTY);
  assign period = adcs_pkg::rate_period(i_rate_select);

  // System clock rate derived from the fast clock
  assign sys_tick = (div_cnt_r == SYS_LAST);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt_r <= 8'h00;
    end else if (sys_tick) begin
      div_cnt_r <= 8'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

  // Modulator rate
  assign mod_tick = sys_tick &&
                    (mod_cnt_r == (turbo ? adcs_pkg::MOD_DIV_TURBO : adcs_pkg::MOD_DIV_NORMAL));
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mod_cnt_r <= 4'h0;
    end else if (mod_tick) begin
      mod_cnt_r <= 4'h0;
    end else if (sys_tick) begin
      mod_cnt_r <= mod_cnt_r + 4'h1;
    end
  end

  // Serial clock edges are ignored while deselected
  assign sclk_rise = i_sclk && !sclk_q_r && !i_cs_n;
  assign sclk_fall = !i_sclk && sclk_q_r && !i_cs_n;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_q_r <= 1'b0;
    end else begin
      sclk_q_r <= i_sclk;
    end
  end

  // Conversion sequencer
  assign dly_done = (cv_state_r == adcs_pkg::CV_DELAY) && sys_tick &&
                    (cnt_r == (turbo ? DLY_T_LAST : DLY_N_LAST));
  assign conv_done = (cv_state_r == adcs_pkg::CV_CONV) && mod_tick &&
                     (cnt_r == period - 17'h00001);
  assign duty_done = (cv_state_r == adcs_pkg::CV_DUTY) && mod_tick &&
                     (cnt_r == 17'(period * adcs_pkg::DUTY_SLEEP_PERIODS) - 17'h00001);

  // Power-up runs one single conversion, as after a sync
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cv_state_r <= adcs_pkg::CV_DELAY;
      cnt_r <= 17'h00000;
      cont_r <= 1'b0;
    end else if (start_cmd_r) begin
      cv_state_r <= adcs_pkg::CV_DELAY;
      cnt_r <= 17'h00000;
      cont_r <= i_conv_mode_bit;
    end else if (cfg_wr_r) begin
      cv_state_r <= adcs_pkg::CV_DELAY;
      cnt_r <= 17'h00000;
      if (cv_state_r == adcs_pkg::CV_IDLE) begin
        cont_r <= 1'b0;
      end
    end else begin
      unique case (cv_state_r)
        adcs_pkg::CV_IDLE: begin
          cnt_r <= 17'h00000;
        end
        adcs_pkg::CV_DELAY: begin
          if (dly_done) begin
            cv_state_r <= adcs_pkg::CV_CONV;
            cnt_r <= 17'h00000;
          end else if (sys_tick) begin
            cnt_r <= cnt_r + 17'h00001;
          end
        end
        adcs_pkg::CV_CONV: begin
          if (conv_done) begin
            cnt_r <= 17'h00000;
            if (sleep_pend_r || !cont_r) begin
              cv_state_r <= adcs_pkg::CV_IDLE;
            end else if (duty) begin
              cv_state_r <= adcs_pkg::CV_DUTY;
            end else begin
              cv_state_r <= adcs_pkg::CV_CONV;
            end
          end else if (mod_tick) begin
            cnt_r <= cnt_r + 17'h00001;
          end
        end
        adcs_pkg::CV_DUTY: begin
          if (sleep_pend_r) begin
            cv_state_r <= adcs_pkg::CV_IDLE;
            cnt_r <= 17'h00000;
          end else if (duty_done) begin
            cv_state_r <= adcs_pkg::CV_CONV;
            cnt_r <= 17'h00000;
          end else if (mod_tick) begin
            cnt_r <= cnt_r + 17'h00001;
          end
        end
      endcase
    end
  end

  // Sleep waits for the running conversion; wake clears power-down
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sleep_pend_r <= 1'b0;
      pd_r <= 1'b0;
    end else if (start_cmd_r || cfg_wr_r) begin
      sleep_pend_r <= 1'b0;
      pd_r <= 1'b0;
    end else if (sleep_cmd_r) begin
      if (cv_state_r == adcs_pkg::CV_CONV || cv_state_r == adcs_pkg::CV_DELAY) begin
        sleep_pend_r <= 1'b1;
      end else begin
        pd_r <= 1'b1;
      end
    end else if (sleep_pend_r && (conv_done || cv_state_r == adcs_pkg::CV_DUTY)) begin
      sleep_pend_r <= 1'b0;
      pd_r <= 1'b1;
    end
  end

  // Result buffer and ready flag; new data wins over a clearing edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      result_r <= '0;
      ready_n_r <= adcs_pkg::RST_READY_N;
    end else if (conv_done) begin
      result_r <= i_conv_result;
      ready_n_r <= 1'b0;
    end else if (sclk_rise) begin
      ready_n_r <= 1'b1;
    end else if (cv_state_r == adcs_pkg::CV_CONV && cont_r && mod_tick &&
                 cnt_r == period - adcs_pkg::READY_PULSE_MOD - 17'h00001) begin
      ready_n_r <= 1'b1;
    end
  end

  // Serial receive and command decode
  assign rx_nxt = {rx_r[6:0], i_din};
  assign byte_done = sclk_fall && (bit_cnt_r == 3'h7);
  assign sp_busy = (bit_cnt_r != 3'h0) || (sp_phase_r != adcs_pkg::SP_CMD);
  assign tout_hit = sp_busy && mod_tick && (tout_r == (turbo ? TOUT_T_LAST : TOUT_N_LAST));
  assign sp_reset = i_cs_n || tout_hit;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tout_r <= 15'h0000;
    end else if (!sp_busy || sp_reset) begin
      tout_r <= 15'h0000;
    end else if (mod_tick) begin
      tout_r <= tout_r + 15'h0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sp_phase_r <= adcs_pkg::SP_CMD;
      rx_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      left_r <= 2'h0;
      addr_r <= 2'h0;
      start_cmd_r <= 1'b0;
      sleep_cmd_r <= 1'b0;
      cfg_wr_r <= 1'b0;
      load_rd_r <= 1'b0;
      o_reg_wr_en <= 1'b0;
      o_reg_wr_addr <= 2'h0;
      o_reg_wr_data <= 8'h00;
    end else begin
      start_cmd_r <= 1'b0;
      sleep_cmd_r <= 1'b0;
      cfg_wr_r <= 1'b0;
      load_rd_r <= 1'b0;
      o_reg_wr_en <= 1'b0;
      if (sp_reset) begin
        sp_phase_r <= adcs_pkg::SP_CMD;
        bit_cnt_r <= 3'h0;
        left_r <= 2'h0;
      end else if (sclk_fall) begin
        rx_r <= rx_nxt;
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (byte_done) begin
          unique case (sp_phase_r)
            adcs_pkg::SP_CMD: begin
              if ((rx_nxt & adcs_pkg::CMD_IGNORE_LSB) == adcs_pkg::CMD_START) begin
                start_cmd_r <= 1'b1;
              end else if ((rx_nxt & adcs_pkg::CMD_IGNORE_LSB) == adcs_pkg::CMD_SLEEP) begin
                sleep_cmd_r <= 1'b1;
              end else if (rx_nxt[7:4] == adcs_pkg::CMD_RD_NIB) begin
                sp_phase_r <= adcs_pkg::SP_RD;
                addr_r <= rx_nxt[3:2];
                left_r <= rx_nxt[1:0];
                load_rd_r <= 1'b1;
              end else if (rx_nxt[7:4] == adcs_pkg::CMD_WR_NIB) begin
                sp_phase_r <= adcs_pkg::SP_WR;
                addr_r <= rx_nxt[3:2];
                left_r <= rx_nxt[1:0];
              end
            end
            adcs_pkg::SP_WR: begin
              o_reg_wr_en <= 1'b1;
              o_reg_wr_addr <= addr_r;
              o_reg_wr_data <= rx_nxt;
              addr_r <= addr_r + 2'h1;
              if (left_r == 2'h0) begin
                sp_phase_r <= adcs_pkg::SP_CMD;
                cfg_wr_r <= 1'b1;
              end else begin
                left_r <= left_r - 2'h1;
              end
            end
            adcs_pkg::SP_RD: begin
              if (left_r == 2'h0) begin
                sp_phase_r <= adcs_pkg::SP_CMD;
              end else begin
                left_r <= left_r - 2'h1;
                addr_r <= addr_r + 2'h1;
                load_rd_r <= 1'b1;
              end
            end
          endcase
        end
      end
    end
  end

  // Transmit shifter; register bytes replace the result during a read
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_r <= '0;
      dout_r <= adcs_pkg::RST_DOUT;
    end else if (load_rd_r) begin
      tx_r <= {i_reg_rd_data, 16'h0000};
    end else if (sclk_rise) begin
      dout_r <= tx_r[adcs_pkg::RESULT_W-1];
      tx_r <= {tx_r[adcs_pkg::RESULT_W-2:0], 1'b0};
    end else if (conv_done && !sp_busy) begin
      // A result landing mid-byte or during a register command is held back so that transfer stays coherent
      tx_r <= i_conv_result;
      if (i_ready_on_dout_select) begin
        dout_r <= 1'b0;
      end
    end else if (i_cs_n) begin
      tx_r <= result_r;
    end
  end

  assign o_dout = dout_r;
  assign o_dout_oe_n = i_cs_n;
  assign o_ready_n = ready_n_r;
  assign o_reg_rd_addr = addr_r;
  assign o_mod_tick = mod_tick;
  assign o_conv_start = dly_done;
  assign o_converting = (cv_state_r == adcs_pkg::CV_CONV);
  // Analog stays on through the start delay so the reference can settle
  assign o_analog_on = (cv_state_r == adcs_pkg::CV_CONV) ||
                       (cv_state_r == adcs_pkg::CV_DELAY);
  assign o_excitation_on = !pd_r;
  assign o_low_side_allow = !pd_r;
  assign o_powered_down = pd_r;

endmodule
`default_nettype wire

/* bench/adcs_chk_assertions.sv */
// Checker bound to the sequencer and serial port
`timescale 1ns/10ps
`default_nettype none
module adcs_chk #(
  parameter int SYS_DIV = adcs_pkg::SYS_DIV_DEFAULT
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Watched ports
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic [1:0] i_op_mode,
  input wire logic i_ready_on_dout_select,
  input wire logic o_dout,
  input wire logic o_dout_oe_n,
  input wire logic o_ready_n,
  input wire logic o_reg_wr_en,
  input wire logic o_mod_tick,
  input wire logic o_conv_start,
  input wire logic o_converting,
  input wire logic o_analog_on,
  input wire logic o_excitation_on,
  input wire logic o_low_side_allow,
  input wire logic o_powered_down
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [15:0] gap_r;
  logic [1:0] mode_r;
  logic ok_r;
  // Spacing is judged only within one conversion in one mode
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gap_r <= 16'h0000;
      mode_r <= 2'h0;
      ok_r <= 1'b0;
    end else begin
      gap_r <= o_mod_tick ? 16'h0000 : gap_r + 16'h0001;
      mode_r <= i_op_mode;
      ok_r <= (o_mod_tick | ok_r) & o_converting & ~o_conv_start & (mode_r == i_op_mode);
    end
  end
  a_oe_follows_cs: assert property (o_dout_oe_n == i_cs_n)
    else $error("shared output enable differs from chip select");
  a_pd_analog_off: assert property (o_powered_down |-> !o_analog_on && !o_excitation_on
    && !o_low_side_allow) else $error("analog still on while powered down");
  a_pd_no_conv: assert property (o_powered_down |-> !o_converting && !o_conv_start)
    else $error("conversion while powered down");
  a_pd_needs_cmd: assert property (o_powered_down && i_cs_n |=> o_powered_down)
    else $error("woke up without a command");
  a_ready_mirror: assert property ($fell(o_ready_n) && i_ready_on_dout_select && !i_cs_n
    |-> !o_dout) else $error("shared output did not fall with ready");
  a_ready_clear: assert property ($rose(i_sclk) && !i_cs_n && !o_ready_n
    |-> ##[1:3] o_ready_n) else $error("ready not cleared by serial clock rise");
  a_start_conv: assert property (o_conv_start |=> o_converting [*4])
    else $error("start pulse without conversion");
  a_wr_after_fall: assert property (o_reg_wr_en |-> !$past(i_sclk) && $past(i_sclk, 2))
    else $error("register write not after a falling serial clock");
  a_tick_spacing: assert property (o_mod_tick && ok_r && mode_r == i_op_mode
    |-> gap_r == ((i_op_mode == adcs_pkg::MODE_TURBO) ? 8 : 16) * SYS_DIV - 1)
    else $error("modulator tick spacing wrong");
endmodule

bind adcs_seq_port adcs_chk #(.SYS_DIV(SYS_DIV)) i_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_sclk(i_sclk),
  .i_op_mode(i_op_mode), .i_ready_on_dout_select(i_ready_on_dout_select),
  .o_dout(o_dout), .o_dout_oe_n(o_dout_oe_n), .o_ready_n(o_ready_n),
  .o_reg_wr_en(o_reg_wr_en), .o_mod_tick(o_mod_tick), .o_conv_start(o_conv_start),
  .o_converting(o_converting), .o_analog_on(o_analog_on),
  .o_excitation_on(o_excitation_on), .o_low_side_allow(o_low_side_allow),
  .o_powered_down(o_powered_down)
);
`default_nettype wire

/* bench/adcs_host.sv */
// Host controller model driving the serial port
`timescale 1ns/10ps
`default_nettype none
module adcs_host (
  // Clock
  input wire logic i_clk,
  // Serial lines
  input wire logic i_dout,
  input wire logic i_dout_oe_n,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_din
);
  logic last_r;
  logic pin;
  // Released pin has no pull, so it shows the inverse of its last level
  always @(posedge i_clk) if (!i_dout_oe_n) last_r <= i_dout;
  assign pin = i_dout_oe_n ? !last_r : i_dout;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_din = 1'b0;
  end
  task automatic sel(input logic on);
    @(negedge i_clk);
    o_sclk <= 1'b0;
    o_cs_n <= !on;
    repeat (2) @(negedge i_clk);
  endtask
  // MSB first; data set at the rise, read back at the fall
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      @(negedge i_clk);
      o_sclk <= 1'b1;
      o_din <= tx[i];
      repeat (2) @(negedge i_clk);
      rx[i] = pin;
      o_sclk <= 1'b0;
      @(negedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the sequencer and serial port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int SD = 2;
  localparam int TN = 20;
  // Start delays in fast clock cycles, measured from the last falling serial edge
  localparam int DN = SD * adcs_pkg::START_DLY_NORMAL;
  localparam int DT = SD * adcs_pkg::START_DLY_TURBO;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmb = 1'b0;
  logic rdsel = 1'b0;
  logic [1:0] mode = adcs_pkg::MODE_NORMAL;
  logic [2:0] rate = 3'h7;
  logic [23:0] res = 24'h8C3A51;
  logic cs_n, sclk, din, dout, oe_n, rdy_n, wr_en, cst, cnv, ana, exc, lsw, pd;
  logic [1:0] wr_a, rd_a;
  logic [7:0] wr_d, r0, r1, r2;
  logic [9:0] wr_last;
  // Configuration register model behind the register access ports
  logic [7:0] regs [4] = '{8'h30, 8'h31, 8'h32, 8'h33};
  logic [7:0] rd_d;
  int fail_count = 0;
  int total_checks = 0;
  int wr_cnt = 0;
  int n;
  always #2.5 clk = ~clk;
  assign rd_d = regs[rd_a];
  adcs_seq_port #(.SYS_DIV(SD), .TOUT_N(TN))
  i_dut (
    .i_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din),
    .o_dout(dout), .o_dout_oe_n(oe_n), .o_ready_n(rdy_n), .i_conv_mode_bit(cmb),
    .i_op_mode(mode), .i_rate_select(rate), .i_ready_on_dout_select(rdsel),
    .o_reg_wr_en(wr_en), .o_reg_wr_addr(wr_a), .o_reg_wr_data(wr_d),
    .o_reg_rd_addr(rd_a), .i_reg_rd_data(rd_d), .i_conv_result(res),
    .o_mod_tick(), .o_conv_start(cst), .o_converting(cnv), .o_analog_on(ana),
    .o_excitation_on(exc), .o_low_side_allow(lsw), .o_powered_down(pd)
  );
  adcs_host i_host (
    .i_clk(clk), .i_dout(dout), .i_dout_oe_n(oe_n), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din)
  );
  always @(posedge clk) begin
    if (wr_en) begin
      wr_cnt <= wr_cnt + 1;
      wr_last <= {wr_a, wr_d};
      regs[wr_a] <= wr_d;
    end
  end
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Bounded wait: 0 ready low, 1 ready high, 2 start pulse, 3 converting
  task automatic wait_on(input int k, input int lim);
    n = 0;
    while (n < lim && (k == 0 ? rdy_n !== 1'b0 : k == 1 ? rdy_n !== 1'b1 :
                       k == 2 ? cst !== 1'b1 : cnv !== 1'b1)) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    i_host.sel(1'b1);
    i_host.xfer(b, 8, r0);
    i_host.sel(1'b0);
  endtask
  task automatic read3(input logic [23:0] exp);
    i_host.sel(1'b1);
    i_host.xfer(8'h00, 8, r0);
    check("rdy_clear", rdy_n, 1'b1);
    i_host.xfer(8'h00, 8, r1);
    i_host.xfer(8'h00, 8, r2);
    i_host.sel(1'b0);
    check("result", {r0, r1, r2}, exp);
  endtask
  initial begin
    // About 69k cycles of tests, so 84k cycles means a hang
    #420000;
    fail_count++;
    $display("unexpected watchdog: expected end of tests, seen hang");
    conclude();
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("ready_rst", rdy_n, adcs_pkg::RST_READY_N);
    check("oe_idle", oe_n, 1'b1);
    wait_on(0, 9000);
    check("pu_done", rdy_n, 1'b0);
    read3(24'h8C3A51);
    check("pu_idle", {cnv, pd}, 2'h0);
    cmb = 1'b1;
    cmd(adcs_pkg::CMD_START);
    wait_on(2, 500);
    check("start_dly", n >= DN - 6 && n <= DN - 2, 1'b1);
    // Half a command, silence past the timeout, then a whole register write
    i_host.sel(1'b1);
    i_host.xfer(8'hFF, 4, r0);
    repeat (TN * 16 * SD + 80) @(negedge clk);
    i_host.xfer(8'h40, 8, r0);
    i_host.xfer(8'h5A, 8, r0);
    wait_on(2, 500);
    check("restart", cst, 1'b1);
    check("wr_first", wr_last, 10'h05A);
    res = 24'h123456;
    rdsel = 1'b1;
    wait_on(0, 9000);
    repeat (3) @(negedge clk);
    check("cont_next", cnv, 1'b1);
    wait_on(1, 9000);
    wait_on(0, 200);
    check("rdy_pulse", n >= 62 && n <= 66, 1'b1);
    check("mirror", dout, 1'b0);
    read3(24'h123456);
    rdsel = 1'b0;
    mode = adcs_pkg::MODE_TURBO;
    cmd(adcs_pkg::CMD_SLEEP | 8'h01);
    check("pd_late", pd, 1'b0);
    wait_on(0, 9000);
    repeat (4) @(negedge clk);
    check("pd_on", {pd, exc, lsw, ana}, 4'h8);
    repeat (300) @(negedge clk);
    check("pd_idle", cnv, 1'b0);
    i_host.sel(1'b1);
    i_host.xfer(8'h21, 8, r0);
    i_host.xfer(8'h00, 8, r1);
    i_host.xfer(8'h00, 8, r2);
    i_host.sel(1'b0);
    check("register_read_cmd", {r1, r2}, 16'h5A31);
    i_host.sel(1'b1);
    i_host.xfer(8'h44, 8, r0);
    i_host.xfer(8'hC3, 8, r0);
    i_host.sel(1'b0);
    wait_on(2, 300);
    check("wake_wr", {pd, cst, wr_last}, 12'h5C3);
    check("turbo_dly", n >= DT - 6 && n <= DT - 2, 1'b1);
    check("wr_count", wr_cnt[3:0], 4'h2);
    wait_on(0, 9000);
    repeat (40) @(negedge clk);
    check("one_shot", cnv, 1'b0);
    mode = adcs_pkg::MODE_DUTY;
    rate = 3'h6;
    cmd(adcs_pkg::CMD_START);
    wait_on(0, 9000);
    repeat (40) @(negedge clk);
    check("duty_rest", {cnv, ana}, 2'h0);
    wait_on(3, 26000);
    check("duty_gap", n >= 24400 && n <= 24700, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
